// ---- core/lasm_pkg.sv ----
/*
 Package for the alarm status / mask block: register offsets, field
 positions, reset values and the packed carriers shared by the design.
 Assumes a classic Wishbone bus with 32-bit data and byte addresses.
*/
package lasm_pkg;

    // ------------------------------------------------------------------
    // Register indices (printed offsets are not word aligned)
    // ------------------------------------------------------------------
    localparam logic [11:0] LASM_IDX_SUMMARY = 12'h2c0;
    localparam logic [11:0] LASM_IDX_STATUS  = 12'h2c1;
    localparam logic [11:0] LASM_IDX_MASK    = 12'h2c2;
    localparam logic [11:0] LASM_IDX_LANE    = 12'h2c4;
    localparam logic [11:0] LASM_IDX_IRQ_ST  = 12'h2c8;
    localparam logic [11:0] LASM_IDX_IRQ_MSK = 12'h2c9;

    // ------------------------------------------------------------------
    // Field positions of status and mask
    // ------------------------------------------------------------------
    localparam int LASM_BIT_DIV   = 0;
    localparam int LASM_BIT_RSV   = 1;
    localparam int LASM_BIT_ALIGN = 2;
    localparam int LASM_BIT_LINK  = 3;
    localparam int LASM_BIT_PLL   = 4;
    localparam int LASM_BIT_FIFO  = 5;

    // ------------------------------------------------------------------
    // Reset values and write masks
    // ------------------------------------------------------------------
    localparam logic [7:0] LASM_STATUS_RST  = 8'h3f;
    localparam logic [7:0] LASM_MASK_RST    = 8'h3f;
    localparam logic [7:0] LASM_LANE_RST    = 8'hff;
    localparam logic [7:0] LASM_STATUS_IMPL = 8'h3d;
    localparam logic [7:0] LASM_IRQ_RST     = 8'h00;
    localparam logic [7:0] LASM_IRQ_MSK_RST = 8'h00;

    // ------------------------------------------------------------------
    // Interrupt event positions
    // ------------------------------------------------------------------
    localparam int LASM_IRQ_SUMMARY = 0;
    localparam int LASM_IRQ_LANE    = 1;

    // ------------------------------------------------------------------
    // Link modes
    // ------------------------------------------------------------------
    typedef enum logic
    {
        LASM_ENC_8B10B  = 1'b0,
        LASM_ENC_64B66B = 1'b1
    } lasm_enc_type;

    // Raw conditions from the link and clock logic
    typedef struct packed
    {
        logic         pll_unlocked;
        logic         link_enable;
        lasm_enc_type enc_mode;
        logic         data_phase_state;
        logic         link_start;
        logic         realign_event;
        logic         sysref_realign;
        logic         div_ab_ne_cd;
        logic [7:0]   lane_fifo_err;
    } lasm_cond_type;

endpackage

// ---- core/lasm_top.sv ----
/*
 Alarm collection block: sticky write-one-to-clear alarm flags, per-lane
 FIFO flags, a mask and a summary alarm, reached over classic Wishbone.
 Assumes raw conditions are synchronous to clk_i.
*/
// Functional notes
// - Flag bit 4 while PLL unlocked.
// - 8B/10B: flag bit 3 outside data state.
// - 64B/66B: flag on link start, realignment.
// - Flag bit 2 on SYSREF clock realignment.
// - Flag bit 0 on divider state mismatch.
// - Write one clears flag; zero keeps it.
// - Reset sets all alarm flags to one.
// - Alarms undefined while link disabled; clear after.
// - Mask bit one blocks flag from summary.
// - Set lane bit on lane FIFO error.
// - Lane clear per bit; persisting error resets.
// - Clearing FIFO flag clears all lanes.
// - Flag bit 5 on any lane FIFO error.
// - Summary is one on unmasked set flag.
`timescale 1ns/1ps

module lasm_top
    import lasm_pkg::*;
(
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // Wishbone slave
    input  wire logic          cyc_i,
    input  wire logic          stb_i,
    input  wire logic          we_i,
    input  wire logic [13:0]   adr_i,
    input  wire logic [3:0]    sel_i,
    input  wire logic [31:0]   dat_i,
    output logic      [31:0]   dat_o,
    output logic               ack_o,
    // Raw conditions
    input  wire lasm_cond_type cond_i,
    // Alarm outputs
    output logic               status_output_pin_o,
    output logic               irq_o
);

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic [7:0]  status_reg;
    logic [7:0]  mask_reg;
    logic [7:0]  lane_reg;
    logic [7:0]  irq_st_reg;
    logic [7:0]  irq_msk_reg;
    logic        summary_reg;
    logic        summary_next;
    logic [11:0] idx;
    logic        req;
    logic        wr_lo;
    logic [7:0]  status_clr;
    logic [7:0]  lane_clr;
    logic [7:0]  status_set;
    logic [7:0]  irq_set;

    assign idx   = adr_i[13:2];
    // One access per request: ack drops in the cycle after it is given
    assign req   = cyc_i && stb_i && !ack_o;
    assign wr_lo = req && we_i && sel_i[0];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= req;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= 32'h0000_0000;
        else if (req && !we_i)
        begin
            case (idx)
                LASM_IDX_SUMMARY: dat_o <= {31'h0000_0000, summary_reg};
                LASM_IDX_STATUS:  dat_o <= {24'h00_0000, status_reg};
                LASM_IDX_MASK:    dat_o <= {24'h00_0000, mask_reg};
                LASM_IDX_LANE:    dat_o <= {24'h00_0000, lane_reg};
                LASM_IDX_IRQ_ST:  dat_o <= {24'h00_0000, irq_st_reg};
                LASM_IDX_IRQ_MSK: dat_o <= {24'h00_0000, irq_msk_reg};
                default:          dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Alarm conditions
    // ------------------------------------------------------------------
    // write-one clear
    assign status_clr = (wr_lo && idx == LASM_IDX_STATUS) ? dat_i[7:0] : 8'h00;
    // fifo flag clear wipes every lane
    assign lane_clr = ((wr_lo && idx == LASM_IDX_LANE) ? dat_i[7:0] : 8'h00)
                    | {8{status_clr[LASM_BIT_FIFO]}};

    always_comb
    begin
        status_set = 8'h00;
        // divider mismatch, valid even with link disabled
        status_set[LASM_BIT_DIV] = cond_i.div_ab_ne_cd;
        status_set[LASM_BIT_ALIGN] = cond_i.sysref_realign;
        // link flag only meaningful with link enabled
        if (cond_i.enc_mode == LASM_ENC_8B10B)
            status_set[LASM_BIT_LINK] = cond_i.link_enable && !cond_i.data_phase_state;
        else
            status_set[LASM_BIT_LINK] = cond_i.link_enable
                                      && (cond_i.link_start || cond_i.realign_event);
        status_set[LASM_BIT_PLL] = cond_i.pll_unlocked;
        status_set[LASM_BIT_FIFO] = |cond_i.lane_fifo_err;
    end

    // ------------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------------
    // flags come up set after reset
    // set wins over clear, flag holds until cleared
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            status_reg <= LASM_STATUS_RST;
        else
            status_reg <= ((status_reg & ~status_clr) | status_set) & LASM_STATUS_RST
                        | (status_reg & ~LASM_STATUS_IMPL & LASM_STATUS_RST);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            lane_reg <= LASM_LANE_RST;
        else
            lane_reg <= (lane_reg & ~lane_clr) | cond_i.lane_fifo_err;
    end

    // reserved bits are stored as written; software keeps them
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mask_reg <= LASM_MASK_RST;
        else if (wr_lo && idx == LASM_IDX_MASK)
            mask_reg <= dat_i[7:0];
    end

    // ------------------------------------------------------------------
    // Summary alarm and interrupt
    // ------------------------------------------------------------------
    // mask one blocks the flag
    assign summary_next = |(status_reg & ~mask_reg & LASM_STATUS_IMPL);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            summary_reg         <= 1'b0;
            status_output_pin_o <= 1'b0;
        end
        else
        begin
            summary_reg         <= summary_next;
            status_output_pin_o <= summary_next;
        end
    end

    always_comb
    begin
        irq_set = 8'h00;
        irq_set[LASM_IRQ_SUMMARY] = summary_reg;
        irq_set[LASM_IRQ_LANE]    = |cond_i.lane_fifo_err;
    end

    // Event set wins over a simultaneous write-one clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_st_reg <= LASM_IRQ_RST;
        else if (wr_lo && idx == LASM_IDX_IRQ_ST)
            irq_st_reg <= (irq_st_reg & ~dat_i[7:0]) | irq_set;
        else
            irq_st_reg <= irq_st_reg | irq_set;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_msk_reg <= LASM_IRQ_MSK_RST;
        else if (wr_lo && idx == LASM_IDX_IRQ_MSK)
            irq_msk_reg <= dat_i[7:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(irq_st_reg & irq_msk_reg);
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence pll_lost_s;
        cond_i.pll_unlocked;
    endsequence

    pll_flag_set_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        pll_lost_s |=> status_reg[LASM_BIT_PLL])
        else $error("pll flag not set");

    link_8b10b_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (cond_i.enc_mode == LASM_ENC_8B10B && cond_i.link_enable
         && !cond_i.data_phase_state) |=> status_reg[LASM_BIT_LINK])
        else $error("link flag missed in 8b10b");

    link_64b66b_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (cond_i.enc_mode == LASM_ENC_64B66B && cond_i.link_enable
         && (cond_i.link_start || cond_i.realign_event)) |=> status_reg[LASM_BIT_LINK])
        else $error("link flag missed in 64b66b");

    realign_flag_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        cond_i.sysref_realign |=> status_reg[LASM_BIT_ALIGN])
        else $error("realign flag not set");

    divider_flag_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        cond_i.div_ab_ne_cd |=> status_reg[LASM_BIT_DIV])
        else $error("divider flag not set");

    w1c_clear_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (status_clr[LASM_BIT_PLL] && !cond_i.pll_unlocked) |=> !status_reg[LASM_BIT_PLL])
        else $error("write one did not clear pll flag");

    reset_value_a: assert property (
        @(posedge clk_i)
        $fell(rst_i) |-> status_reg == LASM_STATUS_RST && lane_reg == LASM_LANE_RST)
        else $error("alarm flags not set after reset");

    summary_mask_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (status_reg[LASM_BIT_PLL] && !mask_reg[LASM_BIT_PLL] && !status_clr[LASM_BIT_PLL])
        |=> status_output_pin_o)
        else $error("unmasked flag missing from summary");

    lane_set_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        cond_i.lane_fifo_err[3] |=> lane_reg[3] && status_reg[LASM_BIT_FIFO])
        else $error("lane flag not set");

    lane_all_clear_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (status_clr[LASM_BIT_FIFO] && cond_i.lane_fifo_err == 8'h00) |=> lane_reg == 8'h00)
        else $error("fifo clear left lane bits");

    sticky_hold_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (status_reg[LASM_BIT_ALIGN] && !status_clr[LASM_BIT_ALIGN])
        |=> status_reg[LASM_BIT_ALIGN])
        else $error("flag dropped without clear");

    fifo_aggregate_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (|cond_i.lane_fifo_err) |=> status_reg[LASM_BIT_FIFO])
        else $error("fifo flag not set on lane error");

    lane_retrip_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (lane_clr[2] && cond_i.lane_fifo_err[2]) |=> lane_reg[2])
        else $error("persisting lane error did not trip again");

    mask_block_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ((status_reg & ~mask_reg & LASM_STATUS_IMPL) == 8'h00) |=> !status_output_pin_o)
        else $error("masked flag reached summary");

    reserved_status_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        status_reg[LASM_BIT_RSV] && status_reg[7:6] == 2'b00)
        else $error("reserved status bits changed");

    irq_level_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (|(irq_st_reg & irq_msk_reg)) |=> irq_o)
        else $error("interrupt not raised for unmasked event");

endmodule

// ---- sim/tb_lasm_top.sv ----
/*
 Self-checking bench for the alarm status / mask block.
 Assumes lasm_pkg and lasm_top from core/ and one 40 MHz clock.
*/
`timescale 1ns/1ps

module tb_lasm_top
    import lasm_pkg::*;
;
    logic          clk_i;
    logic          rst_i;
    logic          cyc_i;
    logic          stb_i;
    logic          we_i;
    logic [13:0]   adr_i;
    logic [3:0]    sel_i;
    logic [31:0]   dat_i;
    logic [31:0]   dat_o;
    logic          ack_o;
    lasm_cond_type cond_i;
    lasm_cond_type idle_c;
    logic          status_output_pin_o;
    logic          irq_o;
    int            bad_count;
    int            cmp_count;
    int            k;
    logic [31:0]   seed;
    logic [7:0]    bit_exp;
    logic [7:0]    lane_exp;
    logic [7:0]    msk;
    logic [1:0]    imsk;
    logic [2:0]    ln;
    logic          sum_exp;

    lasm_top uut
    (
        .clk_i               (clk_i),
        .rst_i               (rst_i),
        .cyc_i               (cyc_i),
        .stb_i               (stb_i),
        .we_i                (we_i),
        .adr_i               (adr_i),
        .sel_i               (sel_i),
        .dat_i               (dat_i),
        .dat_o               (dat_o),
        .ack_o               (ack_o),
        .cond_i              (cond_i),
        .status_output_pin_o (status_output_pin_o),
        .irq_o               (irq_o)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        lfsr = {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h00000000);
    endfunction

    // Status bit raised by each condition code
    function automatic logic [7:0] flag_of(input int c);
        case (c)
            0: flag_of = 8'h10;
            4: flag_of = 8'h04;
            5: flag_of = 8'h01;
            6: flag_of = 8'h20;
            default: flag_of = 8'h08;
        endcase
    endfunction

    task automatic test_done;
        if (bad_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
            bad_count++;
        end
    endtask

    // Classic single cycle; a stuck slave is counted and abandoned
    task automatic wb(input logic w, input logic [11:0] idx, input logic [7:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {idx, 2'b00};
        dat_i <= {24'h0, d};
        sel_i <= 4'h1;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o;
        if (n >= 50)
            bad_count++;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, q);
    endtask

    task automatic rdc(input logic [11:0] idx, input logic [7:0] exp);
        logic [31:0] q;
        wb(1'b0, idx, 8'h00, q);
        chk(q, {24'h0, exp});
    endtask

    // One-cycle pulse of one raw condition on top of the idle pattern
    task automatic fire(input int c, input logic [2:0] ln);
        lasm_cond_type v;
        v = idle_c;
        if (c == 2 || c == 3)
            v.enc_mode = LASM_ENC_64B66B;
        case (c)
            0: v.pll_unlocked = 1'b1;
            1: v.data_phase_state = 1'b0;
            2: v.link_start = 1'b1;
            3: v.realign_event = 1'b1;
            4: v.sysref_realign = 1'b1;
            5: v.div_ab_ne_cd = 1'b1;
            default: v.lane_fifo_err[ln] = 1'b1;
        endcase
        // Whole pattern goes out in one assignment
        @(posedge clk_i);
        cond_i <= v;
        @(posedge clk_i);
        cond_i <= idle_c;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        bad_count = 0;
        cmp_count = 0;
        seed = 32'ha5867f2b;
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = '0;
        sel_i = '0;
        dat_i = '0;
        cond_i = '0;
        idle_c = '0;
        idle_c.link_enable = 1'b1;
        idle_c.data_phase_state = 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(LASM_IDX_STATUS, 8'h3f);
        rdc(LASM_IDX_MASK, 8'h3f);
        rdc(LASM_IDX_LANE, 8'hff);
        rdc(LASM_IDX_SUMMARY, 8'h00);
        wr(LASM_IDX_STATUS, 8'h00);
        rdc(LASM_IDX_STATUS, 8'h3f);
        wr(LASM_IDX_LANE, 8'h0f);
        rdc(LASM_IDX_LANE, 8'hf0);
        wr(LASM_IDX_STATUS, 8'h20);
        rdc(LASM_IDX_LANE, 8'h00);
        rdc(LASM_IDX_STATUS, 8'h1f);
        cond_i <= idle_c;
        wr(LASM_IDX_STATUS, 8'h3d);
        rdc(LASM_IDX_STATUS, 8'h02);
        wr(12'h2ff, 8'hff);
        rdc(12'h2ff, 8'h00);
        for (int i = 0; i < 30; i++)
        begin
            seed = lfsr(seed);
            k = (i < 7) ? i : int'(seed[7:0] % 8'd7);
            // reserved mask bits kept
            // First pass unmasks every flag; lane 3 is always hit once
            msk = (i == 0) ? 8'h02 : ((seed[23:16] & 8'h3d) | 8'h02);
            ln = (i == 6) ? 3'd3 : seed[10:8];
            imsk = seed[25:24];
            wr(LASM_IDX_MASK, msk);
            wr(LASM_IDX_IRQ_MSK, {6'h0, imsk});
            fire(k, ln);
            bit_exp = flag_of(k) | 8'h02;
            lane_exp = (k == 6) ? (8'h01 << ln) : 8'h00;
            sum_exp = |(bit_exp & ~msk & LASM_STATUS_IMPL);
            repeat (4) @(posedge clk_i);
            rdc(LASM_IDX_STATUS, bit_exp);
            rdc(LASM_IDX_LANE, lane_exp);
            rdc(LASM_IDX_MASK, msk);
            rdc(LASM_IDX_SUMMARY, {7'h0, sum_exp});
            chk(32'(status_output_pin_o), 32'(sum_exp));
            rdc(LASM_IDX_IRQ_ST, {6'h0, k == 6, sum_exp});
            chk(32'(irq_o), 32'(|({k == 6, sum_exp} & imsk)));
            wr(LASM_IDX_STATUS, 8'h3d);
            wr(LASM_IDX_LANE, 8'hff);
            repeat (4) @(posedge clk_i);
            rdc(LASM_IDX_STATUS, 8'h02);
            wr(LASM_IDX_IRQ_ST, 8'h03);
            rdc(LASM_IDX_IRQ_ST, 8'h00);
        end
        // A lane error that persists trips again at once
        cond_i.lane_fifo_err <= 8'h04;
        wr(LASM_IDX_LANE, 8'hff);
        rdc(LASM_IDX_LANE, 8'h04);
        rdc(LASM_IDX_STATUS, 8'h22);
        cond_i <= idle_c;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(LASM_IDX_STATUS, 8'h3f);
        rdc(LASM_IDX_LANE, 8'hff);
        test_done;
    end

    // Far beyond the roughly 1400 cycles the sequence needs
    initial
    begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        test_done;
    end
endmodule
